/* design/alu_defines.vh */
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

// Datapath widths
`define ALU_WORD_W      24
`define ALU_IDX_W       15

// Major opcodes (octal)
`define ALU_OP_SKIP_GE  6'o05
`define ALU_OP_MEQ_SRCH 6'o06
`define ALU_OP_MTH_SRCH 6'o07
`define ALU_OP_SKIP_IDX 6'o10
`define ALU_OP_SHIFT1   6'o12
`define ALU_OP_SHIFT2   6'o13
`define ALU_OP_ENTER    6'o14
`define ALU_OP_INCR     6'o15
`define ALU_OP_XOR_IMM  6'o16
`define ALU_OP_AND_IMM  6'o17
`define ALU_OP_LD_DBL   6'o25
`define ALU_OP_LDC_DBL  6'o26
`define ALU_OP_RPL_ADD  6'o34
`define ALU_OP_SEL_SET  6'o35
`define ALU_OP_SEL_CPL  6'o36
`define ALU_OP_MUL      6'o50
`define ALU_OP_DIV      6'o51
`define ALU_OP_CMP3     6'o52
`define ALU_OP_XFER     6'o53
`define ALU_OP_RELOC    6'o55
`define ALU_OP_DIV_DBL  6'o57

// Program advance codes
`define ALU_ADV_REPEAT  2'd0
`define ALU_ADV_P1      2'd1
`define ALU_ADV_P2      2'd2
`define ALU_ADV_P3      2'd3

// Scale loop limit: a 48-bit register can move at most 47 places
`define ALU_SCALE_MAX   6'h2f

// Sequencer states
`define ALU_ST_IDLE     1'b0
`define ALU_ST_SCALE    1'b1

`endif

/* design/alu_instruction_unit.v */
// Behaviour
// - Greater-equal skip: A, Q or index versus y
// - Masked search: decrement index, test, skip/repeat
// - Storage sign skip rotates word, writes back
// - Index skip: clear on match, else step
// - Shift count is k plus index
// - Left shifts rotate, right shifts drop
// - Double shift treats A and Q together
// - Scale rotates until top bits differ
// - Enter clears target and loads y
// - Increase adds y into target
// - Immediate XOR into target register
// - Immediate AND into target register
// - Double load, optionally complemented words
// - Selective set and complement of A
// - Replace add writes sum to memory
// - Multiply gives product in Q then A
// - Divide: quotient in A, remainder Q
// - Three-way compare picks P+1/2/3
// - Index and accumulator transfers, bits 00-14
// - Add accumulator into sign-extended index
// - Relocation select: instruction or operand state
// - Divide fault stops and advances program
// - Auxiliary accumulator is 24-bit register
// - Top bit is one's complement sign
`include "alu_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module alu_instruction_unit #(
  parameter W  = `ALU_WORD_W,
  parameter IW = `ALU_IDX_W
) (
  input  wire          sys_clk,
  input  wire          rstn,
  input  wire          exec_start,
  input  wire [5:0]    opcode,
  input  wire [2:0]    op_sub,
  input  wire [2:0]    op_ext,
  input  wire [IW-1:0] operand_y,
  input  wire [W-1:0]  mem_word,
  input  wire [W-1:0]  mem_word_next,
  input  wire [IW-1:0] prog_addr,
  output wire          busy,
  output reg  [W-1:0]  acc_q,
  output reg  [W-1:0]  aux_q,
  output wire [3*IW-1:0] index_flat,
  output reg           mem_wr_q,
  output reg  [W-1:0]  mem_wr_data_q,
  output reg  [IW-1:0] next_addr_q,
  output reg           next_instruction_read_q,
  output reg           reloc_operand_state_q,
  output reg           divide_fault_q
);
  // One's complement add with end-around carry
  function [23:0] oc_add;
    input [23:0] a;
    input [23:0] b;
    reg   [24:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      oc_add = s[23:0] + {23'h00_0000, s[24]};
    end
  endfunction
  // Signed value of a one's complement word; both zeros map to 0
  function signed [24:0] oc_val;
    input [23:0] x;
    begin
      oc_val = x[23] ? -$signed({1'b0, ~x}) : $signed({1'b0, x});
    end
  endfunction
  function [23:0] sx15;
    input [14:0] v;
    begin
      sx15 = {{9{v[14]}}, v};
    end
  endfunction
  reg  [IW-1:0] idx_q [1:3];
  wire [IW-1:0] idx_rd [0:3];
  reg           idx_we;
  reg  [1:0]    idx_wsel;
  reg  [IW-1:0] idx_wd;
  assign idx_rd[0] = {IW{1'b0}};
  reg         state_q;
  reg  [5:0]  scl_cnt_q;
  reg  [1:0]  scl_b_q;
  reg  [IW-1:0] scl_k_q;
  assign busy = (state_q == `ALU_ST_SCALE);
  wire          go    = exec_start && !busy;
  wire [1:0]    bsel  = op_sub[1:0];
  wire [IW-1:0] idx_b = idx_rd[bsel];
  wire          use_q = op_sub[0];
  wire [W-1:0]  tgt   = use_q ? aux_q : acc_q;
  wire [W-1:0]  y_sx  = sx15(operand_y);
  wire [W-1:0]  y_zx  = {9'h000, operand_y};
  // Sub-codes 4..7: .4/.5 signed forms, .6/.7 plain forms
  wire [W-1:0]  y_sel = op_sub[1] ? y_zx : y_sx;
  wire [W-1:0]  shf_k  = oc_add(y_sx, sx15(idx_b));
  wire          shf_rt = shf_k[23];
  wire [5:0]    shf_n  = shf_rt ? ~shf_k[5:0] : shf_k[5:0];
  wire [5:0]    n24    = shf_n % 6'd24;
  wire [5:0]    n48    = (shf_n >= 6'd48) ? shf_n - 6'd48 : shf_n;
  // Multiply and divide on magnitudes; A is the upper half of the dividend
  wire [22:0] mag_a  = acc_q[23] ? ~acc_q[22:0] : acc_q[22:0];
  wire [22:0] mag_m  = mem_word[23] ? ~mem_word[22:0] : mem_word[22:0];
  wire [45:0] prod   = mag_a * mag_m;
  wire [47:0] aq     = {acc_q, aux_q};
  wire [47:0] aq_mag = acc_q[23] ? ~aq : aq;
  wire [22:0] dv     = (mag_m == 23'h00_0000) ? 23'h00_0001 : mag_m;
  wire [46:0] quo    = aq_mag[46:0] / {24'h00_0000, dv};
  wire [46:0] rem    = aq_mag[46:0] % {24'h00_0000, dv};
  wire        dv_flt = (mag_m == 23'h00_0000) ||
                       (quo[46:23] != 24'h00_0000);
  reg [W-1:0]  acc_d;
  reg [W-1:0]  aux_d;
  reg [1:0]    adv;
  reg          mem_wr_d;
  reg [W-1:0]  mem_data_d;
  reg          reloc_d;
  reg          fault_d;
  reg          scale_go;
  reg [47:0]   dbl;
  reg [W-1:0]  tmp_w;
  always @* begin
    acc_d      = acc_q;
    aux_d      = aux_q;
    adv        = `ALU_ADV_P1;
    idx_we     = 1'b0;
    idx_wsel   = bsel;
    idx_wd     = idx_b;
    mem_wr_d   = 1'b0;
    mem_data_d = mem_word;
    reloc_d    = reloc_operand_state_q;
    fault_d    = 1'b0;
    scale_go   = 1'b0;
    dbl        = 48'h0000_0000_0000;
    tmp_w      = {W{1'b0}};
    case (opcode)
      `ALU_OP_SKIP_GE: begin
        if (op_sub[2] ? (oc_val(tgt) >= oc_val(y_sel)) :
            (oc_val(sx15(idx_b)) >= oc_val(y_sx))) begin
          adv = `ALU_ADV_P2;
        end
      end
      `ALU_OP_MEQ_SRCH, `ALU_OP_MTH_SRCH: begin
        idx_wsel = opcode[0] ? 2'd2 : 2'd1;
        tmp_w    = oc_add(sx15(idx_rd[idx_wsel]), ~y_sx);
        idx_wd   = tmp_w[IW-1:0];
        idx_we   = 1'b1;
        if (tmp_w[IW-1]) begin
          adv = `ALU_ADV_P1;
        end else if (opcode[0] ?
                     (oc_val(acc_q) >= oc_val(aux_q & mem_word)) :
                     (acc_q == (aux_q & mem_word))) begin
          adv = `ALU_ADV_P2;
        end else begin
          adv = `ALU_ADV_REPEAT;
        end
      end
      `ALU_OP_SKIP_IDX: begin
        if (op_sub == 3'd0) begin
          mem_wr_d   = 1'b1;
          mem_data_d = {mem_word[22:0], mem_word[23]};
          adv = mem_word[23] ? `ALU_ADV_P2 : `ALU_ADV_P1;
        end else begin
          idx_we = 1'b1;
          if (idx_b == operand_y) begin
            idx_wd = {IW{1'b0}};
            adv    = `ALU_ADV_P2;
          end else begin
            tmp_w  = oc_add(sx15(idx_b), op_sub[2] ?
                            24'hff_fffe : 24'h00_0001);
            idx_wd = tmp_w[IW-1:0];
          end
        end
      end
      `ALU_OP_SHIFT1: begin
        tmp_w = op_sub[2] ? aux_q : acc_q;
        dbl   = {tmp_w, tmp_w} << n24;
        tmp_w = shf_rt ? tmp_w >> shf_n : dbl[47:24];
        if (op_sub[2]) begin
          aux_d = tmp_w;
        end else begin
          acc_d = tmp_w;
        end
      end
      `ALU_OP_SHIFT2: begin
        if (op_sub[2]) begin
          scale_go = 1'b1;
        end else begin
          if (shf_rt) begin
            dbl = {acc_q, aux_q} >> shf_n;
          end else if (n48 == 6'd0) begin
            dbl = {acc_q, aux_q};
          end else begin
            dbl = ({acc_q, aux_q} << n48) |
                  ({acc_q, aux_q} >> (6'd48 - n48));
          end
          acc_d = dbl[47:24];
          aux_d = dbl[23:0];
        end
      end
      `ALU_OP_ENTER, `ALU_OP_INCR, `ALU_OP_XOR_IMM, `ALU_OP_AND_IMM: begin
        if (op_sub[2]) begin
          case (opcode[1:0])
            2'd0:    tmp_w = y_sel;
            2'd1:    tmp_w = oc_add(tgt, y_sel);
            2'd2:    tmp_w = tgt ^ y_sel;
            default: tmp_w = tgt & y_sel;
          endcase
          if (use_q) begin
            aux_d = tmp_w;
          end else begin
            acc_d = tmp_w;
          end
        end else if (bsel != 2'd0) begin
          idx_we = 1'b1;
          case (opcode[1:0])
            2'd0:    idx_wd = operand_y;
            2'd1: begin
              tmp_w  = oc_add(sx15(idx_b), y_sx);
              idx_wd = tmp_w[IW-1:0];
            end
            2'd2:    idx_wd = idx_b ^ operand_y;
            default: idx_wd = idx_b & operand_y;
          endcase
        end
      end
      `ALU_OP_LD_DBL: begin
        acc_d = mem_word;
        aux_d = mem_word_next;
      end
      `ALU_OP_LDC_DBL: begin
        acc_d = ~mem_word;
        aux_d = ~mem_word_next;
      end
      `ALU_OP_RPL_ADD: begin
        mem_wr_d   = 1'b1;
        mem_data_d = oc_add(acc_q, mem_word);
      end
      `ALU_OP_SEL_SET: acc_d = acc_q | mem_word;
      `ALU_OP_SEL_CPL: acc_d = acc_q ^ mem_word;
      `ALU_OP_MUL: begin
        dbl = (acc_q[23] ^ mem_word[23]) ? ~{2'b00, prod} : {2'b00, prod};
        aux_d = dbl[47:24];
        acc_d = dbl[23:0];
      end
      `ALU_OP_DIV, `ALU_OP_DIV_DBL: begin
        if (dv_flt) begin
          fault_d = 1'b1;
        end else begin
          tmp_w = {1'b0, quo[22:0]};
          acc_d = (acc_q[23] ^ mem_word[23]) ? ~tmp_w : tmp_w;
          tmp_w = {1'b0, rem[22:0]};
          aux_d = acc_q[23] ? ~tmp_w : tmp_w;
        end
      end
      `ALU_OP_CMP3: begin
        if (oc_val(mem_word) > oc_val(acc_q)) begin
          adv = `ALU_ADV_P1;
        end else if (oc_val(aux_q) > oc_val(mem_word)) begin
          adv = `ALU_ADV_P2;
        end else begin
          adv = `ALU_ADV_P3;
        end
      end
      `ALU_OP_XFER: begin
        if (op_ext == 3'd0 && !op_sub[2]) begin
          acc_d = {9'h000, idx_b};
        end else if (op_ext == 3'd0 && bsel != 2'd0) begin
          idx_we = 1'b1;
          idx_wd = acc_q[IW-1:0];
        end else if (op_ext == 3'd4 && op_sub[2] && bsel != 2'd0) begin
          tmp_w  = oc_add(sx15(idx_b), acc_q);
          idx_we = 1'b1;
          idx_wd = tmp_w[IW-1:0];
        end
      end
      `ALU_OP_RELOC: begin
        if (op_sub == 3'd0) begin
          reloc_d = 1'b0;
        end else if (op_sub == 3'd4) begin
          reloc_d = 1'b1;
        end
      end
      default: adv = `ALU_ADV_P1;
    endcase
  end
  always @(posedge sys_clk) begin
    if (!rstn) begin
      acc_q                   <= {W{1'b0}};
      aux_q                   <= {W{1'b0}};
      mem_wr_q                <= 1'b0;
      mem_wr_data_q           <= {W{1'b0}};
      next_addr_q             <= {IW{1'b0}};
      next_instruction_read_q <= 1'b0;
      reloc_operand_state_q   <= 1'b0;
      divide_fault_q          <= 1'b0;
      state_q                 <= `ALU_ST_IDLE;
      scl_cnt_q               <= 6'h00;
      scl_b_q                 <= 2'd0;
      scl_k_q                 <= {IW{1'b0}};
    end else begin
      mem_wr_q                <= 1'b0;
      next_instruction_read_q <= 1'b0;
      divide_fault_q          <= 1'b0;
      case (state_q)
        `ALU_ST_IDLE: begin
          if (go && scale_go) begin
            state_q   <= `ALU_ST_SCALE;
            scl_cnt_q <= 6'h00;
            scl_b_q   <= bsel;
            scl_k_q   <= operand_y;
            next_addr_q <= prog_addr + 15'h0001;
          end else if (go) begin
            acc_q                   <= acc_d;
            aux_q                   <= aux_d;
            mem_wr_q                <= mem_wr_d;
            mem_wr_data_q           <= mem_data_d;
            reloc_operand_state_q   <= reloc_d;
            divide_fault_q          <= fault_d;
            next_addr_q             <= prog_addr + {13'h0000, adv};
            next_instruction_read_q <= 1'b1;
          end
        end
        `ALU_ST_SCALE: begin
          if (acc_q[23] != acc_q[22] || scl_cnt_q == `ALU_SCALE_MAX) begin
            state_q                 <= `ALU_ST_IDLE;
            next_instruction_read_q <= 1'b1;
          end else begin
            acc_q     <= {acc_q[22:0], aux_q[23]};
            aux_q     <= {aux_q[22:0], acc_q[23]};
            scl_cnt_q <= scl_cnt_q + 6'h01;
          end
        end
        default: state_q <= `ALU_ST_IDLE;
      endcase
    end
  end

  // Residue k minus shift count goes to the index unless b is zero
  wire [W-1:0] scl_res = oc_add(sx15(scl_k_q), ~{18'h0_0000, scl_cnt_q});
  wire         scl_end = busy && (acc_q[23] != acc_q[22] ||
                                  scl_cnt_q == `ALU_SCALE_MAX);
  genvar gi;
  generate
    for (gi = 1; gi <= 3; gi = gi + 1) begin : g_idx
      assign idx_rd[gi] = idx_q[gi];
      assign index_flat[gi*IW-1:(gi-1)*IW] = idx_q[gi];
      always @(posedge sys_clk) begin
        if (!rstn) begin
          idx_q[gi] <= {IW{1'b0}};
        end else if (scl_end && scl_b_q == gi) begin
          idx_q[gi] <= scl_res[IW-1:0];
        end else if (go && idx_we && idx_wsel == gi) begin
          idx_q[gi] <= idx_wd;
        end
      end
    end
  endgenerate
endmodule

`default_nettype wire

/* tb/alu_iu_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "alu_defines.vh"
module alu_iu_checker #(
  parameter W  = 24,
  parameter IW = 15
) (
  input wire logic          sys_clk,
  input wire logic          rstn,
  input wire logic          exec_start,
  input wire logic          busy,
  input wire logic [5:0]    opcode,
  input wire logic [2:0]    op_sub,
  input wire logic [IW-1:0] operand_y,
  input wire logic [IW-1:0] prog_addr,
  input wire logic [W-1:0]  mem_word,
  input wire logic [W-1:0]  mem_word_next,
  input wire logic [W-1:0]  acc_q,
  input wire logic [W-1:0]  aux_q,
  input wire logic          mem_wr_q,
  input wire logic [IW-1:0] next_addr_q,
  input wire logic          next_instruction_read_q,
  input wire logic          reloc_operand_state_q,
  input wire logic          divide_fault_q
);
  wire logic tk;
  assign tk = exec_start && !busy;
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  done_a:
    assert property (tk && !(opcode == `ALU_OP_SHIFT2 && op_sub[2])
      |=> next_instruction_read_q
      && IW'(next_addr_q - $past(prog_addr)) <= IW'(3))
    else $error("completion late or next address off");
  dload_a:
    assert property (tk && opcode == `ALU_OP_LD_DBL
      |=> acc_q == $past(mem_word) && aux_q == $past(mem_word_next))
    else $error("double load wrong");
  cload_a:
    assert property (tk && opcode == `ALU_OP_LDC_DBL
      |=> acc_q == ~$past(mem_word) && aux_q == ~$past(mem_word_next))
    else $error("double load complement wrong");
  sset_a:
    assert property (tk && opcode == `ALU_OP_SEL_SET
      |=> acc_q == ($past(acc_q) | $past(mem_word)))
    else $error("selective set wrong");
  scpl_a:
    assert property (tk && opcode == `ALU_OP_SEL_CPL
      |=> acc_q == ($past(acc_q) ^ $past(mem_word)))
    else $error("selective complement wrong");
  xor_a:
    assert property (tk && opcode == `ALU_OP_XOR_IMM && op_sub == 3'd6
      |=> acc_q == ($past(acc_q) ^ W'($past(operand_y))))
    else $error("immediate xor wrong");
  radd_a:
    assert property (tk && opcode == `ALU_OP_RPL_ADD
      |=> mem_wr_q && $stable(acc_q))
    else $error("replace add did not write memory only");
  cmp_a:
    assert property (tk && opcode == `ALU_OP_CMP3
      |=> $stable(acc_q) && $stable(aux_q) && next_addr_q != $past(prog_addr))
    else $error("compare changed registers or did not advance");
  reloc_a:
    assert property (tk && opcode == `ALU_OP_RELOC && op_sub[1:0] == 2'd0
      |=> reloc_operand_state_q == $past(op_sub[2]))
    else $error("relocation select wrong");
  fault_a:
    assert property (divide_fault_q
      |-> next_instruction_read_q && $stable(acc_q) && $stable(aux_q))
    else $error("divide fault did not stop and advance");
  scale_a:
    assert property ($rose(busy) |-> ##[1:60] next_instruction_read_q)
    else $error("scale loop did not finish");
endmodule
bind alu_instruction_unit alu_iu_checker #(.W(W), .IW(IW)) u_alu_iu_checker (.*);
`default_nettype wire

/* tb/alu_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
module alu_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        ld,
  input  wire logic [23:0] ld_lo,
  input  wire logic [23:0] ld_hi,
  input  wire logic        mem_wr_q,
  input  wire logic [23:0] mem_wr_data_q,
  output wire logic [23:0] mem_word,
  output wire logic [23:0] mem_word_next
);
  // Operand pair M, M+1; a write-back replaces M
  logic [23:0] m0_q = 24'h00_0000;
  logic [23:0] m1_q = 24'h00_0000;
  assign mem_word = m0_q;
  assign mem_word_next = m1_q;
  always @(posedge sys_clk) begin
    if (ld) begin
      m0_q <= ld_lo;
      m1_q <= ld_hi;
    end else if (mem_wr_q) begin
      m0_q <= mem_wr_data_q;
    end
  end
endmodule
`default_nettype wire

/* tb/alu_instruction_unit_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module alu_instruction_unit_tb_top;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        exec_start = 1'b0;
  logic [5:0]  opcode = 6'h00;
  logic [2:0]  op_sub = 3'h0;
  logic [2:0]  op_ext = 3'h0;
  logic [14:0] operand_y = 15'h0000;
  logic [14:0] prog_addr = 15'h0000;
  logic        ld = 1'b0;
  logic [23:0] ld_lo = 24'h00_0000;
  logic [23:0] ld_hi = 24'h00_0000;
  logic [23:0] seed = 24'h00_001b;
  logic [23:0] r1;
  logic [23:0] r2;
  logic [14:0] p;
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  wire logic        busy;
  wire logic        wr;
  wire logic        nir;
  wire logic        rel;
  wire logic        flt;
  wire logic [23:0] acc_q;
  wire logic [23:0] aux_q;
  wire logic [23:0] mw;
  wire logic [23:0] mwn;
  wire logic [23:0] wd;
  wire logic [44:0] idx;
  wire logic [14:0] na;
  always #25 sys_clk = ~sys_clk;
  alu_instruction_unit u_alu_instruction_unit (
    .sys_clk(sys_clk), .rstn(rstn), .exec_start(exec_start),
    .opcode(opcode), .op_sub(op_sub), .op_ext(op_ext),
    .operand_y(operand_y), .mem_word(mw), .mem_word_next(mwn),
    .prog_addr(prog_addr), .busy(busy), .acc_q(acc_q), .aux_q(aux_q),
    .index_flat(idx), .mem_wr_q(wr), .mem_wr_data_q(wd),
    .next_addr_q(na), .next_instruction_read_q(nir),
    .reloc_operand_state_q(rel), .divide_fault_q(flt));
  alu_mem_model u_alu_mem_model (
    .sys_clk(sys_clk), .ld(ld), .ld_lo(ld_lo), .ld_hi(ld_hi),
    .mem_wr_q(wr), .mem_wr_data_q(wd), .mem_word(mw),
    .mem_word_next(mwn));
  function automatic logic [23:0] lfsr(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction
  function automatic logic [23:0] sx(input logic [14:0] y);
    return {{9{y[14]}}, y};
  endfunction
  // One's complement sum with end-around carry
  function automatic logic [23:0] oca(input logic [23:0] a, b);
    logic [24:0] s;
    s = a + b;
    return s[23:0] + s[24];
  endfunction
  task automatic chk(input string n, input logic [47:0] s, e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic put(input logic [23:0] lo, hi);
    @(posedge sys_clk);
    ld <= 1'b1;
    ld_lo <= lo;
    ld_hi <= hi;
    @(posedge sys_clk);
    ld <= 1'b0;
  endtask
  task automatic go(input logic [5:0] o, input logic [2:0] s, e,
                    input logic [14:0] y);
    int n;
    n = 0;
    p = {1'b0, seed[13:0]};
    seed = lfsr(seed);
    @(posedge sys_clk);
    exec_start <= 1'b1;
    opcode <= o;
    op_sub <= s;
    op_ext <= e;
    operand_y <= y;
    prog_addr <= p;
    @(posedge sys_clk);
    exec_start <= 1'b0;
    #1;
    while (nir !== 1'b1 && n < 80) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 80)
      err_count++;
  endtask
  task automatic sk(input logic [5:0] o, input logic [2:0] s,
                    input logic [14:0] y, k);
    go(o, s, 3'd0, y);
    chk("P", na, p + k);
  endtask
  task automatic ld2(input logic [23:0] a, q);
    put(a, q);
    go(6'o25, 3'd0, 3'd0, 15'h0000);
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r1 = lfsr(seed);
      r2 = lfsr(r1);
      seed = r2;
      ld2(r1, r2);
      chk("AQ", {acc_q, aux_q}, {r1, r2});
      chk("P", na, p + 15'd1);
      put(r2, r1);
      go(6'o35, 3'd0, 3'd0, 15'h0000);
      chk("A", acc_q, r1 | r2);
      go(6'o36, 3'd0, 3'd0, 15'h0000);
      chk("A", acc_q, r1 & ~r2);
      go(6'o16, 3'd6, 3'd0, r1[14:0]);
      chk("A", acc_q, (r1 & ~r2) ^ {9'h0, r1[14:0]});
      go(6'o17, 3'd5, 3'd0, r2[14:0]);
      chk("Q", aux_q, r2 & sx(r2[14:0]));
      go(6'o26, 3'd0, 3'd0, 15'h0000);
      chk("AQ", {acc_q, aux_q}, {~r2, ~r1});
    end
    go(6'o14, 3'd4, 3'd0, 15'h4001);
    chk("A", acc_q, 24'hff_c001);
    go(6'o14, 3'd6, 3'd0, 15'h4001);
    chk("A", acc_q, 24'h00_4001);
    go(6'o15, 3'd4, 3'd0, 15'h7ffe);
    chk("A", acc_q, oca(24'h00_4001, sx(15'h7ffe)));
    sk(6'o05, 3'd6, 15'h4000, 15'd2);
    sk(6'o05, 3'd6, 15'h4001, 15'd1);
    sk(6'o05, 3'd4, 15'h7ffe, 15'd2);
    go(6'o14, 3'd4, 3'd0, 15'h7ff0);
    sk(6'o05, 3'd4, 15'h7ff1, 15'd1);
    sk(6'o05, 3'd4, 15'h7fef, 15'd2);
    sk(6'o05, 3'd6, 15'h0001, 15'd1);
    put(24'h00_0020, 24'h00_0000);
    go(6'o34, 3'd0, 3'd0, 15'h0000);
    @(posedge sys_clk);
    #1;
    chk("MA", {mw, acc_q}, {24'h00_0011, 24'hff_fff0});
    put(24'h80_0001, 24'h00_0000);
    sk(6'o10, 3'd0, 15'h0000, 15'd2);
    @(posedge sys_clk);
    #1;
    chk("M", mw, 24'h00_0003);
    sk(6'o10, 3'd0, 15'h0000, 15'd1);
    go(6'o53, 3'd5, 3'd0, 15'h0000);
    chk("B1", idx[14:0], 15'h7ff0);
    go(6'o53, 3'd1, 3'd0, 15'h0000);
    chk("A", acc_q, 24'h00_7ff0);
    go(6'o53, 3'd5, 3'd4, 15'h0000);
    chk("B1", idx[14:0], 15'h7fe1);
    go(6'o14, 3'd1, 3'd0, 15'h0005);
    sk(6'o10, 3'd1, 15'h0006, 15'd1);
    chk("B1", idx[14:0], 15'h0006);
    sk(6'o10, 3'd1, 15'h0006, 15'd2);
    sk(6'o10, 3'd5, 15'h0003, 15'd1);
    chk("B1", idx[14:0], 15'h7ffe);
    go(6'o14, 3'd1, 3'd0, 15'h0005);
    go(6'o14, 3'd6, 3'd0, 15'h0012);
    go(6'o14, 3'd7, 3'd0, 15'h00ff);
    put(24'h00_0013, 24'h00_0000);
    sk(6'o06, 3'd0, 15'h0002, 15'd0);
    chk("B1", idx[14:0], 15'h0003);
    put(24'h00_0112, 24'h00_0000);
    sk(6'o06, 3'd0, 15'h0002, 15'd2);
    sk(6'o06, 3'd0, 15'h0003, 15'd1);
    go(6'o14, 3'd2, 3'd0, 15'h0002);
    sk(6'o07, 3'd0, 15'h0001, 15'd2);
    chk("B2", idx[29:15], 15'h0001);
    ld2(24'h80_0001, 24'h00_0003);
    go(6'o12, 3'd0, 3'd0, 15'h0003);
    chk("A", acc_q, 24'h00_000c);
    go(6'o12, 3'd0, 3'd0, 15'h7ffd);
    chk("A", acc_q, 24'h00_0003);
    go(6'o14, 3'd1, 3'd0, 15'h0001);
    go(6'o12, 3'd1, 3'd0, 15'h0001);
    chk("A", acc_q, 24'h00_000c);
    go(6'o12, 3'd4, 3'd0, 15'h0004);
    chk("Q", aux_q, 24'h00_0030);
    ld2(24'h80_0001, 24'h80_0000);
    go(6'o13, 3'd0, 3'd0, 15'h0001);
    chk("AQ", {acc_q, aux_q}, 48'h00_0003_00_0001);
    go(6'o13, 3'd0, 3'd0, 15'h7ffe);
    chk("AQ", {acc_q, aux_q}, 48'h00_0001_80_0000);
    ld2(24'h00_0001, 24'h00_0000);
    go(6'o13, 3'd4, 3'd0, 15'd30);
    chk("A", acc_q, 24'h40_0000);
    ld2(24'h00_0001, 24'h00_0000);
    go(6'o13, 3'd5, 3'd0, 15'd30);
    chk("B1", idx[14:0], 15'd8);
    ld2(24'h00_0123, 24'h00_0000);
    put(24'h00_0100, 24'h00_0000);
    go(6'o50, 3'd0, 3'd0, 15'h0000);
    chk("QA", {aux_q, acc_q}, 48'h0000_0001_2300);
    ld2(24'h00_0000, 24'h00_0107);
    put(24'h00_0010, 24'h00_0000);
    go(6'o51, 3'd0, 3'd0, 15'h0000);
    chk("AQ", {acc_q, aux_q}, 48'h00_0010_00_0007);
    put(24'h00_0000, 24'h00_0000);
    sk(6'o51, 3'd0, 15'h0000, 15'd1);
    chk("F", flt, 1'b1);
    chk("AQ", {acc_q, aux_q}, 48'h00_0010_00_0007);
    sk(6'o57, 3'd0, 15'h0000, 15'd1);
    chk("F", flt, 1'b1);
    ld2(24'h00_0020, 24'h00_0010);
    put(24'h00_0030, 24'h00_0000);
    sk(6'o52, 3'd0, 15'h0000, 15'd1);
    put(24'h00_0008, 24'h00_0000);
    sk(6'o52, 3'd0, 15'h0000, 15'd2);
    put(24'h00_0018, 24'h00_0000);
    sk(6'o52, 3'd0, 15'h0000, 15'd3);
    go(6'o55, 3'd4, 3'd0, 15'h0000);
    chk("R", rel, 1'b1);
    go(6'o55, 3'd0, 3'd0, 15'h0000);
    chk("R", rel, 1'b0);
    results();
  end
endmodule
`default_nettype wire
